// >>> mixer_regs_pkg.sv
// Constants for the record path mixer and converter enable register bank
// Overview of operation
// - Reg 02h bits 9/8 enable left/right mixers
// - Reg 29h bits 8/5 unmute left PGA paths
// - Reg 29h bits 7/4 select 30dB boost
// - Reg 2Bh bits 8:6 left line gain
// - Reg 2Ah bits 8/5 unmute right PGA paths
// - Reg 2Ah bits 7/4 select right boost
// - Reg 2Ch bits 8:6 right line gain
// - Reg 02h bits 1/0 enable left/right converters
// - Reg 7Ah bit 15 enables converter sync
// - Each converter yields 24-bit 64x samples
package mixer_regs_pkg;

  // ****************************************
  // Register indices and address width
  // ****************************************
  localparam logic [7:0] IDX_PATH_POWER = 8'h02;
  localparam logic [7:0] IDX_LEFT_PGA = 8'h29;
  localparam logic [7:0] IDX_RIGHT_PGA = 8'h2A;
  localparam logic [7:0] IDX_LEFT_LINE = 8'h2B;
  localparam logic [7:0] IDX_RIGHT_LINE = 8'h2C;
  localparam logic [7:0] IDX_EXT_GATE = 8'h75;
  localparam logic [7:0] IDX_SYNC_LINK = 8'h7A;
  localparam int ADDR_W = 10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int POS_LEFT_PATH = 9;
  localparam int POS_RIGHT_PATH = 8;
  localparam int POS_LEFT_CONV = 1;
  localparam int POS_RIGHT_CONV = 0;
  localparam int POS_PGA_B_UNMUTE = 8;
  localparam int POS_PGA_B_BOOST = 7;
  localparam int POS_PGA_A_UNMUTE = 5;
  localparam int POS_PGA_A_BOOST = 4;
  localparam int POS_LINE_LSB = 6;
  localparam int LINE_W = 3;
  localparam int POS_EXT_UNLOCK = 1;
  localparam int POS_SYNC = 15;

  // ****************************************
  // Reset values and converter shape
  // ****************************************
  localparam logic RST_BIT = 1'b0;
  localparam logic [2:0] RST_LINE_GAIN = 3'h0;
  localparam logic [2:0] LINE_MUTE = 3'h0;
  localparam int SAMPLE_W = 24;
  localparam int OSR = 64;
  localparam int OSR_W = 6;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> input_mixer_adc_enable_regs.sv
// Register bank for input mixers, line gains and converter enables
//
// Register access over AXI4-Lite is this design's own decision.
module input_mixer_adc_enable_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // AXI4-Lite write address
  input wire logic [9:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [9:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Mixer controls
  output logic left_path_enable,
  output logic right_path_enable,
  output logic left_pga_b_unmute,
  output logic left_pga_b_boost,
  output logic left_pga_a_unmute,
  output logic left_pga_a_boost,
  output logic [2:0] left_line_pin_gain,
  output logic right_pga_b_unmute,
  output logic right_pga_b_boost,
  output logic right_pga_a_unmute,
  output logic right_pga_a_boost,
  output logic [2:0] right_line_pin_gain,
  // Converter controls and samples
  output logic left_converter_enable,
  output logic right_converter_enable,
  output logic extended_map_unlock,
  output logic converter_sync_enable,
  input wire logic left_modulator_bit,
  input wire logic right_modulator_bit,
  output logic [23:0] left_sample,
  output logic [23:0] right_sample,
  output logic sample_valid
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic [2:0] decode(input logic [9:0] addr);
    logic [2:0] sel;
    sel = 3'h7;
    if (addr[1:0] == 2'h0) begin
      if (addr[9:2] == mixer_regs_pkg::IDX_PATH_POWER) sel = 3'h0;
      if (addr[9:2] == mixer_regs_pkg::IDX_LEFT_PGA) sel = 3'h1;
      if (addr[9:2] == mixer_regs_pkg::IDX_RIGHT_PGA) sel = 3'h2;
      if (addr[9:2] == mixer_regs_pkg::IDX_LEFT_LINE) sel = 3'h3;
      if (addr[9:2] == mixer_regs_pkg::IDX_RIGHT_LINE) sel = 3'h4;
      if (addr[9:2] == mixer_regs_pkg::IDX_EXT_GATE) sel = 3'h5;
      if (addr[9:2] == mixer_regs_pkg::IDX_SYNC_LINK) sel = 3'h6;
    end
    return sel;
  endfunction

  // ****************************************
  // Write channel capture
  // ****************************************
  logic aw_held_reg;
  logic w_held_reg;
  logic [9:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic [9:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [2:0] wr_sel;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  assign wr_fire = (aw_held_reg || (s_axi_awvalid && s_axi_awready))
    && (w_held_reg || (s_axi_wvalid && s_axi_wready));
  assign wr_sel = decode(wr_addr);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 10'h000;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mixer_regs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel == 3'h7) ? mixer_regs_pkg::RESP_SLVERR
        : mixer_regs_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic lo_en;
  logic hi_en;
  assign lo_en = wr_fire && wr_strb[0];
  assign hi_en = wr_fire && wr_strb[1];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      left_path_enable <= mixer_regs_pkg::RST_BIT;
      right_path_enable <= mixer_regs_pkg::RST_BIT;
    end else if (hi_en && wr_sel == 3'h0) begin
      left_path_enable <= wr_data[mixer_regs_pkg::POS_LEFT_PATH];
      right_path_enable <= wr_data[mixer_regs_pkg::POS_RIGHT_PATH];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      left_converter_enable <= mixer_regs_pkg::RST_BIT;
      right_converter_enable <= mixer_regs_pkg::RST_BIT;
    end else if (lo_en && wr_sel == 3'h0) begin
      left_converter_enable <= wr_data[mixer_regs_pkg::POS_LEFT_CONV];
      right_converter_enable <= wr_data[mixer_regs_pkg::POS_RIGHT_CONV];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      left_pga_b_unmute <= mixer_regs_pkg::RST_BIT;
      left_pga_a_unmute <= mixer_regs_pkg::RST_BIT;
    end else if (wr_sel == 3'h1) begin
      if (hi_en) left_pga_b_unmute <= wr_data[mixer_regs_pkg::POS_PGA_B_UNMUTE];
      if (lo_en) left_pga_a_unmute <= wr_data[mixer_regs_pkg::POS_PGA_A_UNMUTE];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      left_pga_b_boost <= mixer_regs_pkg::RST_BIT;
      left_pga_a_boost <= mixer_regs_pkg::RST_BIT;
    end else if (lo_en && wr_sel == 3'h1) begin
      left_pga_b_boost <= wr_data[mixer_regs_pkg::POS_PGA_B_BOOST];
      left_pga_a_boost <= wr_data[mixer_regs_pkg::POS_PGA_A_BOOST];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      right_pga_b_unmute <= mixer_regs_pkg::RST_BIT;
      right_pga_a_unmute <= mixer_regs_pkg::RST_BIT;
    end else if (wr_sel == 3'h2) begin
      if (hi_en) right_pga_b_unmute <= wr_data[mixer_regs_pkg::POS_PGA_B_UNMUTE];
      if (lo_en) right_pga_a_unmute <= wr_data[mixer_regs_pkg::POS_PGA_A_UNMUTE];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      right_pga_b_boost <= mixer_regs_pkg::RST_BIT;
      right_pga_a_boost <= mixer_regs_pkg::RST_BIT;
    end else if (lo_en && wr_sel == 3'h2) begin
      right_pga_b_boost <= wr_data[mixer_regs_pkg::POS_PGA_B_BOOST];
      right_pga_a_boost <= wr_data[mixer_regs_pkg::POS_PGA_A_BOOST];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      left_line_pin_gain <= mixer_regs_pkg::RST_LINE_GAIN;
    end else if (wr_sel == 3'h3) begin
      if (lo_en) left_line_pin_gain[1:0] <= wr_data[mixer_regs_pkg::POS_LINE_LSB +: 2];
      if (hi_en) left_line_pin_gain[2] <= wr_data[mixer_regs_pkg::POS_LINE_LSB + 2];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      right_line_pin_gain <= mixer_regs_pkg::RST_LINE_GAIN;
    end else if (wr_sel == 3'h4) begin
      if (lo_en) right_line_pin_gain[1:0] <= wr_data[mixer_regs_pkg::POS_LINE_LSB +: 2];
      if (hi_en) right_line_pin_gain[2] <= wr_data[mixer_regs_pkg::POS_LINE_LSB + 2];
    end
  end

  // Extended map unlock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      extended_map_unlock <= mixer_regs_pkg::RST_BIT;
    end else if (lo_en && wr_sel == 3'h5) begin
      extended_map_unlock <= wr_data[mixer_regs_pkg::POS_EXT_UNLOCK];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      converter_sync_enable <= mixer_regs_pkg::RST_BIT;
    end else if (hi_en && wr_sel == 3'h6 && extended_map_unlock) begin
      converter_sync_enable <= wr_data[mixer_regs_pkg::POS_SYNC];
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic [31:0] rd_word;
  logic [2:0] rd_sel;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_sel = decode(s_axi_araddr);

  always_comb begin
    rd_word = 32'h00000000;
    unique case (rd_sel)
      3'h0: begin
        rd_word[mixer_regs_pkg::POS_LEFT_PATH] = left_path_enable;
        rd_word[mixer_regs_pkg::POS_RIGHT_PATH] = right_path_enable;
        rd_word[mixer_regs_pkg::POS_LEFT_CONV] = left_converter_enable;
        rd_word[mixer_regs_pkg::POS_RIGHT_CONV] = right_converter_enable;
      end
      3'h1: begin
        rd_word[mixer_regs_pkg::POS_PGA_B_UNMUTE] = left_pga_b_unmute;
        rd_word[mixer_regs_pkg::POS_PGA_B_BOOST] = left_pga_b_boost;
        rd_word[mixer_regs_pkg::POS_PGA_A_UNMUTE] = left_pga_a_unmute;
        rd_word[mixer_regs_pkg::POS_PGA_A_BOOST] = left_pga_a_boost;
      end
      3'h2: begin
        rd_word[mixer_regs_pkg::POS_PGA_B_UNMUTE] = right_pga_b_unmute;
        rd_word[mixer_regs_pkg::POS_PGA_B_BOOST] = right_pga_b_boost;
        rd_word[mixer_regs_pkg::POS_PGA_A_UNMUTE] = right_pga_a_unmute;
        rd_word[mixer_regs_pkg::POS_PGA_A_BOOST] = right_pga_a_boost;
      end
      3'h3: rd_word[mixer_regs_pkg::POS_LINE_LSB +: 3] = left_line_pin_gain;
      3'h4: rd_word[mixer_regs_pkg::POS_LINE_LSB +: 3] = right_line_pin_gain;
      3'h5: rd_word[mixer_regs_pkg::POS_EXT_UNLOCK] = extended_map_unlock;
      3'h6: rd_word[mixer_regs_pkg::POS_SYNC] = converter_sync_enable;
      3'h7: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= mixer_regs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= (rd_sel == 3'h7) ? mixer_regs_pkg::RESP_SLVERR
        : mixer_regs_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Converter decimation
  // ****************************************
  logic [1:0] left_sync_reg;
  logic [1:0] right_sync_reg;
  logic [5:0] phase_reg;
  logic [23:0] left_acc_reg;
  logic [23:0] right_acc_reg;
  logic any_on;
  logic phase_end;
  assign any_on = left_converter_enable || right_converter_enable;
  assign phase_end = phase_reg == 6'(mixer_regs_pkg::OSR - 1);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      left_sync_reg <= 2'h0;
      right_sync_reg <= 2'h0;
    end else begin
      left_sync_reg <= {left_sync_reg[0], left_modulator_bit};
      right_sync_reg <= {right_sync_reg[0], right_modulator_bit};
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= 6'h00;
    end else if (!any_on || (!converter_sync_enable && !(left_converter_enable
        && right_converter_enable) && phase_end)) begin
      phase_reg <= 6'h00;
    end else begin
      phase_reg <= phase_reg + 6'h01;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      left_acc_reg <= 24'h000000;
      right_acc_reg <= 24'h000000;
      left_sample <= 24'h000000;
      right_sample <= 24'h000000;
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= any_on && phase_end;
      left_acc_reg <= (phase_end ? 24'h000000 : left_acc_reg)
        + {23'h000000, left_sync_reg[1] & left_converter_enable};
      right_acc_reg <= (phase_end ? 24'h000000 : right_acc_reg)
        + {23'h000000, right_sync_reg[1] & right_converter_enable};
      if (phase_end) begin
        left_sample <= left_converter_enable ? left_acc_reg : 24'h000000;
        right_sample <= right_converter_enable ? right_acc_reg : 24'h000000;
      end
    end
  end

endmodule

// >>> mixer_regs_chk_sva.sv
// Port checker for the mixer and converter register bank
module mixer_regs_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Controls
  input wire logic left_path_enable,
  input wire logic right_path_enable,
  input wire logic left_pga_b_unmute,
  input wire logic left_pga_a_boost,
  input wire logic [2:0] left_line_pin_gain,
  input wire logic [2:0] right_line_pin_gain,
  input wire logic left_converter_enable,
  input wire logic right_converter_enable,
  input wire logic extended_map_unlock,
  input wire logic converter_sync_enable,
  input wire logic sample_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [6:0] gap;
  logic seen;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gap <= 7'h0;
      seen <= 1'h0;
    end else begin
      gap <= sample_valid ? 7'h0 : gap + 7'h1;
      seen <= (sample_valid | seen) & (left_converter_enable | right_converter_enable)
        & !$changed({left_converter_enable, right_converter_enable});
    end
  end
  // ****
  // Assertions
  // ****
  property p_wr_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("write taken while response pending");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_en;
    $changed({left_path_enable, right_path_enable, left_converter_enable,
      right_converter_enable}) |-> $rose(s_axi_bvalid);
  endproperty
  a_en: assert property (p_en) else $error("enable moved without write");
  property p_pga;
    $changed({left_pga_b_unmute, left_pga_a_boost}) |-> $rose(s_axi_bvalid);
  endproperty
  a_pga: assert property (p_pga) else $error("routing moved without write");
  property p_gain;
    $changed({left_line_pin_gain, right_line_pin_gain}) |-> $rose(s_axi_bvalid);
  endproperty
  a_gain: assert property (p_gain) else $error("line gain moved without write");
  property p_sync;
    $rose(converter_sync_enable) |-> extended_map_unlock;
  endproperty
  a_sync: assert property (p_sync) else $error("sync set while locked");
  property p_sv_gap;
    sample_valid && seen |-> gap == 7'h3F;
  endproperty
  a_sv_gap: assert property (p_sv_gap) else $error("sample spacing wrong");
  property p_sv_off;
    !left_converter_enable && !right_converter_enable
      && $stable({left_converter_enable, right_converter_enable}) |-> !sample_valid;
  endproperty
  a_sv_off: assert property (p_sv_off) else $error("sample while converters off");
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_sync: cover property ($rose(converter_sync_enable));
  c_sv: cover property (sample_valid && seen);
endmodule
bind input_mixer_adc_enable_regs mixer_regs_chk chk_u (.*);

// >>> testbench.sv
// Self-checking bench for the mixer and converter register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] OK = mixer_regs_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = mixer_regs_pkg::RESP_SLVERR;
  localparam logic [7:0] P = mixer_regs_pkg::IDX_PATH_POWER;
  localparam logic [7:0] LP = mixer_regs_pkg::IDX_LEFT_PGA;
  localparam logic [7:0] RP = mixer_regs_pkg::IDX_RIGHT_PGA;
  localparam logic [7:0] LL = mixer_regs_pkg::IDX_LEFT_LINE;
  localparam logic [7:0] RL = mixer_regs_pkg::IDX_RIGHT_LINE;
  localparam logic [7:0] EG = mixer_regs_pkg::IDX_EXT_GATE;
  localparam logic [7:0] SL = mixer_regs_pkg::IDX_SYNC_LINK;
  localparam logic [7:0] IDXS [7] = '{P, LP, RP, LL, RL, EG, SL};
  logic clock, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot, left_line_pin_gain, right_line_pin_gain;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic left_path_enable, right_path_enable, left_pga_b_unmute, left_pga_b_boost;
  logic left_pga_a_unmute, left_pga_a_boost, right_pga_b_unmute, right_pga_b_boost;
  logic right_pga_a_unmute, right_pga_a_boost, left_converter_enable, right_converter_enable;
  logic extended_map_unlock, converter_sync_enable, left_modulator_bit, right_modulator_bit;
  logic [23:0] left_sample, right_sample;
  logic sample_valid;
  logic [31:0] mir [0:127];
  logic [33:0] rq [$];
  logic [1:0] bq [$];
  int n_errors, samples_checked, n;
  input_mixer_adc_enable_regs dut_u (.*);
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end
  // ****
  // Helpers
  // ****
  task automatic final_report;
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  function automatic logic [31:0] view(input logic [7:0] i);
    case (i)
      P: view = {22'h0, left_path_enable, right_path_enable, 6'h0, left_converter_enable,
        right_converter_enable};
      LP: view = {23'h0, left_pga_b_unmute, left_pga_b_boost, 1'h0, left_pga_a_unmute,
        left_pga_a_boost, 4'h0};
      RP: view = {23'h0, right_pga_b_unmute, right_pga_b_boost, 1'h0, right_pga_a_unmute,
        right_pga_a_boost, 4'h0};
      LL: view = {23'h0, left_line_pin_gain, 6'h0};
      RL: view = {23'h0, right_line_pin_gain, 6'h0};
      EG: view = {30'h0, extended_map_unlock, 1'h0};
      SL: view = {16'h0, converter_sync_enable, 15'h0};
      default: view = 32'h0;
    endcase
  endfunction
  function automatic logic [31:0] mask(input logic [7:0] i);
    case (i)
      P: mask = 32'h303;
      LP, RP: mask = 32'h1B0;
      LL, RL: mask = 32'h1C0;
      EG: mask = 32'h2;
      SL: mask = 32'h8000;
      default: mask = 32'h0;
    endcase
  endfunction
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] r);
    @(posedge clock);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'($urandom);
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1 && s_axi_bready !== 1'h1) s_axi_bready <= 1'h1;
    end while (s_axi_bvalid !== 1'h1 || s_axi_bready !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clock);
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'($urandom);
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1 && s_axi_rready !== 1'h1) s_axi_rready <= 1'h1;
    end while (s_axi_rvalid !== 1'h1 || s_axi_rready !== 1'h1);
    s_axi_rready <= 1'h0;
  endtask
  task automatic wcr(input logic [7:0] i, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & mask(i);
    if (!(i == SL && !mir[EG][1])) mir[i] = (mir[i] & ~m) | (d & m);
    wr({i, 2'h0}, d, s, OK);
    chk("ctl", {2'h0, mir[i]}, {2'h0, view(i)});
    rd({i, 2'h0}, mir[i], OK);
  endtask
  task automatic wait_sv;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (sample_valid !== 1'h1 && n < 300);
  endtask
  always @(posedge clock) begin
    if (s_axi_bvalid && s_axi_bready) chk("bresp", 34'(bq.pop_front()), 34'(s_axi_bresp));
    if (s_axi_rvalid && s_axi_rready) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
  end
  initial begin
    repeat (6000) @(posedge clock);
    n_errors++;
    final_report();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    {rstn, s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid} = '0;
    {s_axi_rready, left_modulator_bit, right_modulator_bit} = '0;
    foreach (mir[k]) mir[k] = 32'h0;
    void'($urandom(32'h51DF));
    repeat (6) @(posedge clock);
    rstn <= 1'h1;
    for (int k = 0; k < 7; k++) begin
      chk("rst", 34'h0, {2'h0, view(IDXS[k])});
      rd({IDXS[k], 2'h0}, 32'h0, OK);
    end
    wcr(P, 32'h303, 4'hF);
    wcr(P, 32'h0, 4'h2);
    repeat (4) begin
      wcr(LP, $urandom, 4'hF);
      wcr(RP, $urandom, 4'hF);
    end
    for (int k = 0; k < 8; k++) begin
      wcr(LL, 32'(k) << 6, 4'h3);
      wcr(RL, 32'(7 - k) << 6, 4'h3);
    end
    wcr(SL, 32'h8000, 4'hF);
    wcr(EG, 32'h2, 4'hF);
    wcr(SL, 32'hFFFF, 4'hF);
    wr(10'h004, 32'hFFFFFFFF, 4'hF, ERR);
    wr(10'h009, 32'h0, 4'hF, ERR);
    chk("ctl", {2'h0, mir[P]}, {2'h0, view(P)});
    rd(10'h3FC, 32'h0, ERR);
    wcr(P, 32'h0, 4'h1);
    left_modulator_bit <= 1'h1;
    right_modulator_bit <= 1'h1;
    wcr(P, 32'h2, 4'hF);
    wait_sv();
    wait_sv();
    chk("gap", 34'(mixer_regs_pkg::OSR), 34'(n));
    chk("left", 34'(mixer_regs_pkg::OSR), 34'(left_sample));
    chk("right", 34'h0, 34'(right_sample));
    rstn <= 1'h0;
    repeat (2) @(posedge clock);
    for (int k = 0; k < 7; k++) chk("rst2", 34'h0, {2'h0, view(IDXS[k])});
    final_report();
  end
endmodule
